/* File: design/wdr_top.sv */
`timescale 1ns/100ps

// Overview of operation
// - Watchdog reset sets flag; POR or zero-write clears.
// - Brown-out sets flag; POR or zero-write clears.
// - External reset sets flag; POR or zero-write clears.
// - POR sets its flag; only zero-write clears.
// - Change-enable self-clears after four clock cycles.
// - Enable cleared by a write only while change-enable is one; any chip reset also clears it.
// - Writing one enables; permitted zero disables.
// - Prescaler changes accepted only while change-enable active.
// - Prescaler code selects 16K doubling to 2048K.
// - Timeout gives one-cycle reset pulse.
// - Counter restarts on restart, disable, chip reset.
// - Counter runs on dedicated 1 MHz tick.
// - Safety fuse keeps watchdog on, reads one.
module wdr_top
#(
	parameter int TIMEOUT_BASE = wdr_pkg::TIMEOUT_BASE_OSC
)
(
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic [5:0] io_addr,
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	input  wire logic       poweron_event,
	input  wire logic       external_event,
	input  wire logic       brownout_event,
	input  wire logic       watchdog_restart_instruction,
	input  wire logic       always_on_safety_fuse,
	output logic            wdt_reset_pulse
);

	localparam int CW_CNT_W = $clog2(wdr_pkg::CHANGE_WINDOW_CYCLES);

	logic                         osc_tick;
	logic                         wr_ctrl;
	logic                         wr_cause;
	logic                         arm_wr;
	logic                         chip_rst;
	logic                         wde_eff;
	logic [wdr_pkg::WDT_CNT_W-1:0] timeout_m1;

	wdr_pkg::wdr_window_t         win_q;
	wdr_pkg::wdr_window_t         win_d;
	logic [CW_CNT_W-1:0]          win_cnt_q;
	logic [CW_CNT_W-1:0]          win_cnt_d;
	logic                         wde_q;
	logic                         wde_d;
	logic [2:0]                   presc_q;
	logic [2:0]                   presc_d;
	logic [3:0]                   cause_q;
	logic [3:0]                   cause_d;
	logic [wdr_pkg::WDT_CNT_W-1:0] wdt_cnt_q;
	logic [wdr_pkg::WDT_CNT_W-1:0] wdt_cnt_d;
	logic                         pulse_q;
	logic                         pulse_d;
	logic [7:0]                   rdata_q;
	logic [7:0]                   rdata_d;
	logic                         ce_q;

	// The watchdog oscillator is modelled as an enable from clk_sys, so the
	// settings need no crossing and no write can be lost.
	wdr_tick_div
	#(
		.DIV (wdr_pkg::OSC_DIV_CYCLES)
	)
	u_osc_div
	(
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.tick    (osc_tick)
	);

	assign wr_ctrl  = io_wr && (io_addr == wdr_pkg::ADDR_WATCHDOG_CONTROL);
	assign wr_cause = io_wr && (io_addr == wdr_pkg::ADDR_RESET_CAUSE_STATUS);
	assign arm_wr   = wr_ctrl && io_wdata[wdr_pkg::CTRL_CHANGE_ENABLE_BIT]
		&& io_wdata[wdr_pkg::CTRL_WATCHDOG_ENABLE_BIT];
	assign chip_rst = poweron_event || external_event || brownout_event || pulse_q;
	assign ce_q     = (win_q == wdr_pkg::CW_OPEN);
	assign wde_eff  = wde_q || always_on_safety_fuse;
	assign timeout_m1 = wdr_pkg::WDT_CNT_W'(TIMEOUT_BASE << presc_q)
		- wdr_pkg::WDT_CNT_W'(1);

	// Change window, enable and prescaler.
	always_comb
	begin
		win_d     = win_q;
		win_cnt_d = win_cnt_q;
		wde_d     = wde_q;
		presc_d   = presc_q;
		if (ce_q)
		begin
			win_cnt_d = win_cnt_q - CW_CNT_W'(1);
			if (win_cnt_q == '0)
				win_d = wdr_pkg::CW_CLOSED;
		end
		if (wr_ctrl)
		begin
			if (ce_q)
			begin
				wde_d   = io_wdata[wdr_pkg::CTRL_WATCHDOG_ENABLE_BIT];
				presc_d = io_wdata[wdr_pkg::CTRL_PRESCALER_MSB:wdr_pkg::CTRL_PRESCALER_LSB];
				if (!io_wdata[wdr_pkg::CTRL_CHANGE_ENABLE_BIT])
					win_d = wdr_pkg::CW_CLOSED;
			end
			else
			begin
				wde_d = wde_q || io_wdata[wdr_pkg::CTRL_WATCHDOG_ENABLE_BIT];
			end
			if (arm_wr)
			begin
				win_d     = wdr_pkg::CW_OPEN;
				win_cnt_d = CW_CNT_W'(wdr_pkg::CHANGE_WINDOW_CYCLES - 1);
			end
		end
		if (chip_rst)
		begin
			win_d     = wdr_pkg::CW_CLOSED;
			win_cnt_d = '0;
			wde_d     = wdr_pkg::WATCHDOG_CONTROL_RESET[wdr_pkg::CTRL_WATCHDOG_ENABLE_BIT];
			presc_d   = wdr_pkg::WATCHDOG_CONTROL_RESET[2:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			win_q     <= wdr_pkg::CW_CLOSED;
			win_cnt_q <= '0;
			wde_q     <= wdr_pkg::WATCHDOG_CONTROL_RESET[wdr_pkg::CTRL_WATCHDOG_ENABLE_BIT];
			presc_q   <= wdr_pkg::WATCHDOG_CONTROL_RESET[2:0];
		end
		else
		begin
			win_q     <= win_d;
			win_cnt_q <= win_cnt_d;
			wde_q     <= wde_d;
			presc_q   <= presc_d;
		end
	end

	// Watchdog counter and reset pulse.
	always_comb
	begin
		wdt_cnt_d = wdt_cnt_q;
		pulse_d   = 1'b0;
		if (chip_rst || watchdog_restart_instruction || !wde_eff)
			wdt_cnt_d = '0;
		else if (osc_tick)
		begin
			if (wdt_cnt_q >= timeout_m1)
			begin
				wdt_cnt_d = '0;
				pulse_d   = 1'b1;
			end
			else
				wdt_cnt_d = wdt_cnt_q + wdr_pkg::WDT_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			wdt_cnt_q <= '0;
			pulse_q   <= 1'b0;
		end
		else
		begin
			wdt_cnt_q <= wdt_cnt_d;
			pulse_q   <= pulse_d;
		end
	end

	// Reset cause flags; a new event wins over a software clear in the same cycle.
	always_comb
	begin
		cause_d = cause_q;
		if (wr_cause)
			cause_d = cause_q & io_wdata[3:0];
		if (poweron_event)
		begin
			cause_d[wdr_pkg::CAUSE_WATCHDOG_BIT] = 1'b0;
			cause_d[wdr_pkg::CAUSE_BROWNOUT_BIT] = 1'b0;
			cause_d[wdr_pkg::CAUSE_EXTERNAL_BIT] = 1'b0;
			cause_d[wdr_pkg::CAUSE_POWERON_BIT]  = 1'b1;
		end
		if (pulse_q)
			cause_d[wdr_pkg::CAUSE_WATCHDOG_BIT] = 1'b1;
		if (brownout_event)
			cause_d[wdr_pkg::CAUSE_BROWNOUT_BIT] = 1'b1;
		if (external_event)
			cause_d[wdr_pkg::CAUSE_EXTERNAL_BIT] = 1'b1;
	end

	// Read data is registered; unmapped addresses read as zero.
	always_comb
	begin
		rdata_d = 8'h00;
		if (io_rd && io_addr == wdr_pkg::ADDR_WATCHDOG_CONTROL)
			rdata_d = {3'b000, ce_q, wde_eff, presc_q};
		else if (io_rd && io_addr == wdr_pkg::ADDR_RESET_CAUSE_STATUS)
			rdata_d = {4'h0, cause_q};
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			cause_q <= wdr_pkg::RESET_CAUSE_STATUS_RESET[3:0];
			rdata_q <= 8'h00;
		end
		else
		begin
			cause_q <= cause_d;
			rdata_q <= rdata_d;
		end
	end

	assign io_rdata        = rdata_q;
	assign wdt_reset_pulse = pulse_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	property p_ce_self_clear;
		($rose(ce_q) && !arm_wr && !chip_rst) ##1 (!arm_wr && !chip_rst)[*3] |-> ##1 !ce_q;
	endproperty
	a_ce_self_clear: assert property (p_ce_self_clear) else $error("change enable not cleared");

	property p_wde_hold;
		(wr_ctrl && !io_wdata[3] && !ce_q && wde_q && !chip_rst) |=> wde_q;
	endproperty
	a_wde_hold: assert property (p_wde_hold) else $error("enable cleared without window");

	property p_wde_set;
		(wr_ctrl && io_wdata[3] && !chip_rst) |=> wde_q;
	endproperty
	a_wde_set: assert property (p_wde_set) else $error("enable write of one ignored");

	property p_presc_lock;
		(wr_ctrl && !ce_q && !chip_rst) |=> $stable(presc_q);
	endproperty
	a_presc_lock: assert property (p_presc_lock) else $error("prescaler changed while locked");

	property p_fuse_reads_one;
		(always_on_safety_fuse && io_rd && io_addr == wdr_pkg::ADDR_WATCHDOG_CONTROL)
			|=> io_rdata[3];
	endproperty
	a_fuse_reads_one: assert property (p_fuse_reads_one) else $error("fuse enable not read as one");

	property p_watchdog_reset_flag_set;
		wdt_reset_pulse |=> cause_q[3];
	endproperty
	a_watchdog_reset_flag_set: assert property (p_watchdog_reset_flag_set) else $error("watchdog flag not set");

	property p_poweron_reset_flag;
		(poweron_event && !external_event && !brownout_event && !wdt_reset_pulse)
			|=> (cause_q == 4'h1);
	endproperty
	a_poweron_reset_flag: assert property (p_poweron_reset_flag) else $error("power-on flags wrong");

	property p_bor;
		brownout_event |=> cause_q[2];
	endproperty
	a_bor: assert property (p_bor) else $error("brown-out flag not set");

	property p_pulse_one;
		wdt_reset_pulse |=> !wdt_reset_pulse ##1 (wdt_cnt_q == 22'h0);
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");

	property p_restart;
		watchdog_restart_instruction |=> (wdt_cnt_q == 22'h0);
	endproperty
	a_restart: assert property (p_restart) else $error("counter not restarted");

	c_window: cover property ($rose(ce_q));
	c_disable: cover property ($fell(wde_q) && !$past(chip_rst));
	c_timeout: cover property (wdt_reset_pulse);

endmodule

/* File: design/wdr_pkg.sv */
package wdr_pkg;

	// Register offsets in the processor I/O space.
	localparam logic [5:0] ADDR_WATCHDOG_CONTROL    = 6'h21;
	localparam logic [5:0] ADDR_RESET_CAUSE_STATUS  = 6'h34;

	// Field positions of watchdog_control.
	localparam int CTRL_CHANGE_ENABLE_BIT   = 4;
	localparam int CTRL_WATCHDOG_ENABLE_BIT = 3;
	localparam int CTRL_PRESCALER_MSB       = 2;
	localparam int CTRL_PRESCALER_LSB       = 0;

	// Field positions of reset_cause_status.
	localparam int CAUSE_WATCHDOG_BIT = 3;
	localparam int CAUSE_BROWNOUT_BIT = 2;
	localparam int CAUSE_EXTERNAL_BIT = 1;
	localparam int CAUSE_POWERON_BIT  = 0;

	// Reset values.
	localparam logic [7:0] WATCHDOG_CONTROL_RESET   = 8'h00;
	localparam logic [7:0] RESET_CAUSE_STATUS_RESET = 8'h00;

	// Timing: change window and the watchdog oscillator tick.
	localparam int CHANGE_WINDOW_CYCLES = 4;
	localparam int CLK_PERIOD_NS        = 25;
	localparam int OSC_PERIOD_NS        = 1000;
	localparam int OSC_DIV_CYCLES       = OSC_PERIOD_NS / CLK_PERIOD_NS;

	// Shortest timeout in watchdog oscillator cycles, code 000.
	localparam int TIMEOUT_BASE_OSC = 16384;
	localparam int WDT_CNT_W        = 22;

	typedef enum logic [1:0]
	{
		CW_CLOSED = 2'b01,
		CW_OPEN   = 2'b10
	} wdr_window_t;

endpackage

/* File: design/wdr_tick_div.sv */
`timescale 1ns/100ps

// Divides clk_sys into a one-cycle enable pulse every DIV cycles.
module wdr_tick_div
#(
	parameter int DIV = 40
)
(
	input  wire logic clk_sys,
	input  wire logic reset_n,
	output logic      tick
);

	localparam int CW = $clog2(DIV);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          tick_q;
	logic          tick_d;

	always_comb
	begin
		tick_d = (cnt_q == CW'(DIV - 1));
		cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule

/* File: test/tb_wdr_top.sv */
`timescale 1ns/100ps

module tb_wdr_top;
	localparam int         TB    = 4;
	localparam int         DIV   = wdr_pkg::OSC_DIV_CYCLES;
	localparam logic [5:0] CTRL  = wdr_pkg::ADDR_WATCHDOG_CONTROL;
	localparam logic [5:0] CAUSE = wdr_pkg::ADDR_RESET_CAUSE_STATUS;

	logic        clk_sys;
	logic        reset_n;
	logic [5:0]  io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic        poweron_event;
	logic        external_event;
	logic        brownout_event;
	logic        watchdog_restart_instruction;
	logic        always_on_safety_fuse;
	logic        wdt_reset_pulse;
	int          bad_count;
	int          n_compared;
	int          pulses;
	int          p0;
	integer      seed;
	logic [31:0] r;
	logic [7:0]  c_exp;
	logic [2:0]  e;

	wdr_top #(.TIMEOUT_BASE(TB)) wdr_top_i
	(
		.clk_sys                      (clk_sys),
		.reset_n                      (reset_n),
		.io_addr                      (io_addr),
		.io_wr                        (io_wr),
		.io_rd                        (io_rd),
		.io_wdata                     (io_wdata),
		.io_rdata                     (io_rdata),
		.poweron_event                (poweron_event),
		.external_event               (external_event),
		.brownout_event               (brownout_event),
		.watchdog_restart_instruction (watchdog_restart_instruction),
		.always_on_safety_fuse        (always_on_safety_fuse),
		.wdt_reset_pulse              (wdt_reset_pulse)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
		if (wdt_reset_pulse === 1'b1)
			pulses++;

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic chk_win(input string name, input int lo, input int hi, input int seen);
		n_compared++;
		if (seen < lo || seen > hi)
		begin
			bad_count++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, seen);
		end
	endtask

	// The wr and rd drivers start at a falling edge and let one idle edge pass after the strobe
	// drops, so two calls in a row never drive one strobe twice in a time step.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clk_sys);
		io_wr = 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk_sys);
		io_rd = 1'b0;
		d = io_rdata;
		@(negedge clk_sys);
	endtask

	task automatic rd_chk(input string name, input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(name, exp, d);
	endtask

	task automatic ev(input logic [2:0] v);
		{poweron_event, external_event, brownout_event} = v;
		@(negedge clk_sys);
		{poweron_event, external_event, brownout_event} = 3'b000;
	endtask

	task automatic restart();
		watchdog_restart_instruction = 1'b1;
		@(negedge clk_sys);
		watchdog_restart_instruction = 1'b0;
	endtask

	// The tick phase is unknown at restart, so the window allows one tick of slack.
	task automatic expire(input int t);
		int n;
		n = 0;
		restart();
		while (wdt_reset_pulse !== 1'b1 && n < t * DIV + 60)
		begin
			@(negedge clk_sys);
			n++;
		end
		chk_win("timeout cycles", (t - 1) * DIV - 2, t * DIV + 44, n);
		@(negedge clk_sys);
		chk("pulse after one cycle", 8'h00, {7'h00, wdt_reset_pulse});
	endtask

	// A power-on event wipes the other causes, but a cause in the same cycle still lands.
	function automatic logic [7:0] cause_next(input logic [7:0] c, input logic [2:0] v);
		logic [7:0] n;
		n = v[2] ? 8'h01 : c;
		n[1] = n[1] | v[1];
		n[2] = n[2] | v[0];
		return n;
	endfunction

	initial
	begin
		#2_000_000;
		bad_count++;
		report_and_stop();
	end

	initial
	begin
		seed = 32'ha935_04c1;
		{reset_n, io_wr, io_rd, poweron_event, external_event, brownout_event} = 6'h00;
		{watchdog_restart_instruction, always_on_safety_fuse} = 2'b00;
		io_addr = 6'h00;
		io_wdata = 8'h00;
		pulses = 0;
		repeat (12) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		rd_chk("control reset", CTRL, wdr_pkg::WATCHDOG_CONTROL_RESET);
		rd_chk("cause reset", CAUSE, wdr_pkg::RESET_CAUSE_STATUS_RESET);
		rd_chk("unmapped", 6'h00, 8'h00);
		c_exp = 8'h00;
		repeat (24)
		begin
			r = $random(seed);
			e = r[2:0];
			ev(e);
			c_exp = cause_next(c_exp, e);
			rd_chk("cause set", CAUSE, c_exp);
			wr(CAUSE, r[15:8]);
			c_exp = c_exp & r[15:8];
			rd_chk("cause clear", CAUSE, c_exp);
		end
		wr(CAUSE, 8'h00);
		wr(CTRL, 8'h08);
		rd_chk("enable", CTRL, 8'h08);
		wr(CTRL, 8'h00);
		rd_chk("plain disable", CTRL, 8'h08);
		wr(CTRL, 8'h0d);
		rd_chk("plain prescale", CTRL, 8'h08);
		wr(CTRL, 8'h10);
		rd_chk("bit4 alone", CTRL, 8'h08);
		wr(CTRL, 8'h18);
		rd_chk("window open", CTRL, 8'h18);
		repeat (5) @(negedge clk_sys);
		rd_chk("window self close", CTRL, 8'h08);
		wr(CTRL, 8'h18);
		wr(CTRL, 8'h00);
		rd_chk("disable back to back", CTRL, 8'h00);
		wr(CTRL, 8'h08);
		wr(CTRL, 8'h18);
		// The zero write lands on the fourth and last cycle of the window.
		repeat (2) @(negedge clk_sys);
		wr(CTRL, 8'h00);
		rd_chk("disable late in window", CTRL, 8'h00);
		wr(CTRL, 8'h08);
		wr(CTRL, 8'h18);
		repeat (5) @(negedge clk_sys);
		wr(CTRL, 8'h00);
		rd_chk("disable after window", CTRL, 8'h08);
		wr(CTRL, 8'h18);
		wr(CTRL, 8'h00);
		p0 = pulses;
		repeat (400) @(negedge clk_sys);
		chk("disabled pulses", 8'h00, 8'(pulses - p0));
		for (int p = 0; p < 8; p++)
		begin
			wr(CTRL, 8'h08);
			wr(CTRL, 8'h18);
			wr(CTRL, {5'b00001, 3'(p)});
			rd_chk("prescale set", CTRL, {5'b00001, 3'(p)});
			expire(TB << p);
			rd_chk("watchdog flag", CAUSE, 8'h08);
			rd_chk("control after timeout", CTRL, 8'h00);
			wr(CAUSE, 8'h00);
		end
		wr(CTRL, 8'h08);
		p0 = pulses;
		repeat (10)
		begin
			r = $random(seed);
			restart();
			repeat (20 + r[5:0]) @(negedge clk_sys);
		end
		chk("kept alive pulses", 8'h00, 8'(pulses - p0));
		wr(CTRL, 8'h18);
		wr(CTRL, 8'h00);
		always_on_safety_fuse = 1'b1;
		@(negedge clk_sys);
		rd_chk("fuse reads on", CTRL, 8'h08);
		wr(CTRL, 8'h18);
		wr(CTRL, 8'h00);
		rd_chk("fuse blocks disable", CTRL, 8'h08);
		expire(TB);
		rd_chk("fuse timeout flag", CAUSE, 8'h08);
		always_on_safety_fuse = 1'b0;
		ev(3'b010);
		rd_chk("external kept", CAUSE, 8'h0a);
		ev(3'b100);
		rd_chk("poweron wipes", CAUSE, 8'h01);
		ev(3'b001);
		rd_chk("brownout", CAUSE, 8'h05);
		report_and_stop();
	end
endmodule
